//--- hw/pta_target.sv
// Purpose: management-bus target with strap addressing, telemetry refresh and latched status
// Assumes: i_rst is the input-power-cycle reset; status and telemetry inputs are on i_clock
// Notes:   packet error codes are neither sent nor checked
//
// Notes on behaviour
// - bus address is base address plus the four-bit strap index.
// - base address comes from bits 7..5 of config register at command e0.
// - base defaults to 60, giving addresses 60 through 6f.
// - new base only takes effect after input power is cycled.
// - strap index 0..15 from strap resistor; open pin means 15.
// - device may stretch bus clock; host waits while it is held low.
// - busy flag set in status when too occupied to serve the bus.
// - telemetry readings refresh every 0.25 ms.
// - status reported in overview, vout, iout, input, temp, comms, mfr groups.
// - status bits stay set until the clear-faults command 03.
// - re-enabling the output leaves latched status unchanged.
// - interface works at 100 kHz and 400 kHz bus clocks.
// - no packet error code generated or checked.
// - overview word carries a power-good flag.

`timescale 1ns/1ps

module pta_target
  import pta_pkg::*;
#(
  parameter int REFRESH_CYCLES = PTA_REFRESH_CYC
)
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [3:0] i_strap_resistor,
  input  wire logic       i_strap_open,
  input  wire logic [7:0] i_nvm_base,
  input  wire logic       i_busy,
  input  wire logic       i_output_off,
  input  wire logic       i_power_good,
  input  wire pta_stat_t  i_stat_set,
  input  wire pta_telem_t i_telem,
  output logic            o_scl,
  output logic            o_scl_oe,
  output logic            o_sda,
  output logic            o_sda_oe,
  output logic [6:0]      o_target_addr,
  output logic            o_addr_locked,
  output logic [7:0]      o_target_base_config
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pta_state_t            st;
    logic [3:0]            bitcnt;
    logic [7:0]            shift;
    logic [7:0]            tx;
    logic [7:0]            cmd;
    logic [1:0]            byte_idx;
    logic                  rw;
    logic                  nack;
    logic                  scl_d;
    logic                  sda_d;
    logic                  scl_oe;
    logic                  sda_oe;
    logic                  pin_lo;
    logic [1:0]            lock_cnt;
    logic                  locked;
    logic [6:0]            addr;
    logic [7:0]            base_cfg;
    logic                  busy_st;
    pta_stat_t             stat;
    pta_telem_t            telem;
    logic [PTA_REFR_W-1:0] refr_cnt;
  } pta_regs_t;

  pta_regs_t              r_ff;
  pta_regs_t              nxt_r;
  logic [PTA_SYNC_W-1:0]  sync_w;
  logic                   scl_s;
  logic                   sda_s;
  logic [3:0]             strap_s;
  logic                   open_s;
  logic [3:0]             strap_idx;
  logic                   start_w;
  logic                   stop_w;
  logic                   rise_w;
  logic                   fall_w;

  // ****************************************
  // pin synchronisers
  // ****************************************
  pta_sync u_sync
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_scl, i_sda, i_strap_resistor, i_strap_open}),
    .o_sync  (sync_w)
  );

  assign {scl_s, sda_s, strap_s, open_s} = sync_w;
  assign strap_idx = open_s ? PTA_STRAP_OPEN : strap_s;

  // sampling at 100 MHz leaves 250 samples per bit at 400 kHz
  assign start_w = scl_s && r_ff.scl_d && r_ff.sda_d && !sda_s;
  assign stop_w  = scl_s && r_ff.scl_d && !r_ff.sda_d && sda_s;
  assign rise_w  = scl_s && !r_ff.scl_d;
  assign fall_w  = !scl_s && r_ff.scl_d;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [6:0] calc_addr(input logic [7:0] cfg, input logic [3:0] idx);
    logic [7:0] sum;
    sum = {cfg[PTA_BASE_MSB:PTA_BASE_LSB], 5'h00} + {4'h0, idx};
    return sum[6:0];
  endfunction

  function automatic logic [7:0] ovw_byte(input pta_regs_t s, input logic off);
    logic [7:0] b;
    b                  = 8'h00;
    b[PTA_OVW_BUSY]    = s.busy_st;
    b[PTA_OVW_OFF]     = off;
    b[PTA_OVW_VOUT_OV] = s.stat.vout[7];
    b[PTA_OVW_IOUT_OC] = s.stat.iout[7];
    b[PTA_OVW_VIN_UV]  = s.stat.vin[PTA_INP_UV_BIT];
    b[PTA_OVW_TEMP]    = |s.stat.temp;
    b[PTA_OVW_CML]     = |s.stat.cml;
    b[PTA_OVW_OTHER]   = (|s.stat.mfr) || (|s.stat.vin);
    return b;
  endfunction

  function automatic logic [7:0] ovw_hi(input pta_regs_t s, input logic pg);
    logic [7:0] b;
    b               = 8'h00;
    b[PTA_HI_VOUT]  = |s.stat.vout;
    b[PTA_HI_IOUT]  = |s.stat.iout;
    b[PTA_HI_INPUT] = |s.stat.vin;
    b[PTA_HI_MFR]   = |s.stat.mfr;
    b[PTA_HI_PG_N]  = !pg;
    return b;
  endfunction

  function automatic logic [7:0] word_sel(input logic [15:0] w, input logic [1:0] idx);
    // low byte first; bytes past the word read as filler, never as a check code
    case (idx)
      2'd0:    return w[7:0];
      2'd1:    return w[15:8];
      default: return PTA_NO_DATA;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input pta_regs_t s, input logic [1:0] idx,
                                         input logic off, input logic pg);
    logic [7:0] b0;
    b0 = PTA_NO_DATA;
    case (s.cmd)
      PTA_CMD_STAT_BYTE:  b0 = ovw_byte(s, off);
      PTA_CMD_STAT_WORD:  return word_sel({ovw_hi(s, pg), ovw_byte(s, off)}, idx);
      PTA_CMD_STAT_VOUT:  b0 = s.stat.vout;
      PTA_CMD_STAT_IOUT:  b0 = s.stat.iout;
      PTA_CMD_STAT_INPUT: b0 = s.stat.vin;
      PTA_CMD_STAT_TEMP:  b0 = s.stat.temp;
      PTA_CMD_STAT_CML:   b0 = s.stat.cml;
      PTA_CMD_STAT_MFR:   b0 = s.stat.mfr;
      PTA_CMD_BASE_CFG:   b0 = s.base_cfg;
      PTA_CMD_READ_VIN:   return word_sel(s.telem.vin, idx);
      PTA_CMD_READ_VOUT:  return word_sel(s.telem.vout, idx);
      PTA_CMD_READ_IOUT:  return word_sel(s.telem.iout, idx);
      PTA_CMD_READ_POUT:  return word_sel(s.telem.pout, idx);
      PTA_CMD_READ_TEMP:  return word_sel(s.telem.temp, idx);
      default:            b0 = PTA_NO_DATA;
    endcase
    return (idx == 2'd0) ? b0 : PTA_NO_DATA;
  endfunction

  function automatic logic known_cmd(input logic [7:0] c);
    case (c)
      PTA_CMD_CLEAR_FAULTS, PTA_CMD_BASE_CFG, PTA_CMD_STAT_BYTE, PTA_CMD_STAT_WORD,
      PTA_CMD_STAT_VOUT, PTA_CMD_STAT_IOUT, PTA_CMD_STAT_INPUT, PTA_CMD_STAT_TEMP,
      PTA_CMD_STAT_CML, PTA_CMD_STAT_MFR, PTA_CMD_READ_VIN, PTA_CMD_READ_VOUT,
      PTA_CMD_READ_IOUT, PTA_CMD_READ_POUT, PTA_CMD_READ_TEMP:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic      clear;
    pta_stat_t evt;
    clear    = 1'b0;
    evt      = '0;
    nxt_r    = r_ff;
    nxt_r.scl_d = scl_s;
    nxt_r.sda_d = sda_s;

    // address fixed once after power-up; later config writes wait for the next cycle
    if (!r_ff.locked)
    begin
      nxt_r.lock_cnt = r_ff.lock_cnt + 2'd1;
      if (r_ff.lock_cnt == 2'd3)
      begin
        nxt_r.locked   = 1'b1;
        nxt_r.base_cfg = i_nvm_base;
        nxt_r.addr     = calc_addr(i_nvm_base, strap_idx);
      end
    end

    if (r_ff.refr_cnt == PTA_REFR_W'(REFRESH_CYCLES - 1))
    begin
      nxt_r.refr_cnt = '0;
      nxt_r.telem    = i_telem;
    end
    else
    begin
      nxt_r.refr_cnt = r_ff.refr_cnt + PTA_REFR_W'(1);
    end

    if (start_w)
    begin
      nxt_r.st     = ST_ADDR;
      nxt_r.bitcnt = 4'h0;
      nxt_r.sda_oe = 1'b0;
    end
    else if (stop_w)
    begin
      nxt_r.st     = ST_IDLE;
      nxt_r.sda_oe = 1'b0;
    end
    else if (rise_w && r_ff.st != ST_IDLE)
    begin
      nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
      nxt_r.shift  = {r_ff.shift[6:0], sda_s};
      nxt_r.nack   = sda_s;
    end
    else if (fall_w)
    begin
      case (r_ff.st)
        ST_ADDR:
        begin
          if (r_ff.bitcnt == 4'h8)
          begin
            nxt_r.bitcnt = 4'h0;
            if (r_ff.locked && r_ff.shift[7:1] == r_ff.addr)
            begin
              nxt_r.st     = ST_AACK;
              nxt_r.rw     = r_ff.shift[0];
              nxt_r.sda_oe = 1'b1;
            end
            else
            begin
              nxt_r.st = ST_IDLE;
            end
          end
        end
        ST_AACK:
        begin
          nxt_r.bitcnt = 4'h0;
          if (r_ff.rw)
          begin
            nxt_r.tx       = rd_byte(r_ff, 2'd0, i_output_off, i_power_good);
            nxt_r.sda_oe   = !nxt_r.tx[7];
            nxt_r.byte_idx = 2'd1;
            nxt_r.st       = ST_TX;
          end
          else
          begin
            nxt_r.sda_oe   = 1'b0;
            nxt_r.byte_idx = 2'd0;
            nxt_r.st       = ST_RX;
          end
        end
        ST_RX:
        begin
          if (r_ff.bitcnt == 4'h8)
          begin
            if (r_ff.byte_idx == 2'd0)
            begin
              nxt_r.cmd = r_ff.shift;
              clear     = (r_ff.shift == PTA_CMD_CLEAR_FAULTS);
              evt.cml[PTA_CML_BADCMD] = !known_cmd(r_ff.shift);
            end
            else if (r_ff.byte_idx == 2'd1 && r_ff.cmd == PTA_CMD_BASE_CFG)
            begin
              nxt_r.base_cfg = r_ff.shift;
            end
            // extra bytes are taken and dropped; no check code is expected
            if (r_ff.byte_idx != 2'd3)
            begin
              nxt_r.byte_idx = r_ff.byte_idx + 2'd1;
            end
            nxt_r.sda_oe = 1'b1;
            nxt_r.st     = ST_RXACK;
          end
        end
        ST_RXACK:
        begin
          nxt_r.bitcnt = 4'h0;
          nxt_r.sda_oe = 1'b0;
          nxt_r.st     = ST_RX;
        end
        ST_TX:
        begin
          if (r_ff.bitcnt == 4'h8)
          begin
            nxt_r.bitcnt = 4'h0;
            nxt_r.sda_oe = 1'b0;
            nxt_r.st     = ST_TXACK;
          end
          else
          begin
            nxt_r.tx     = {r_ff.tx[6:0], 1'b0};
            nxt_r.sda_oe = !r_ff.tx[6];
          end
        end
        ST_TXACK:
        begin
          nxt_r.bitcnt = 4'h0;
          if (r_ff.nack)
          begin
            nxt_r.st = ST_IDLE;
          end
          else
          begin
            nxt_r.tx     = rd_byte(r_ff, r_ff.byte_idx, i_output_off, i_power_good);
            nxt_r.sda_oe = !nxt_r.tx[7];
            nxt_r.st     = ST_TX;
            if (r_ff.byte_idx != 2'd3)
            begin
              nxt_r.byte_idx = r_ff.byte_idx + 2'd1;
            end
          end
        end
        default:
        begin
          nxt_r.st = ST_IDLE;
        end
      endcase
    end

    // hold scl low only once the host has pulled it low, and only while occupied
    nxt_r.scl_oe = i_busy && !scl_s && r_ff.st != ST_IDLE && r_ff.st != ST_ADDR;

    // a new event in the clear cycle survives; output re-enable has no path here
    nxt_r.stat    = (clear ? pta_stat_t'('0) : r_ff.stat) | i_stat_set | evt;
    nxt_r.busy_st = (clear ? 1'b0 : r_ff.busy_st) | i_busy;
    nxt_r.pin_lo  = 1'b0;                                                          // open drain only pulls low
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_ff          <= '0;
      r_ff.st       <= ST_IDLE;
      r_ff.scl_d    <= 1'b1;
      r_ff.sda_d    <= 1'b1;
      r_ff.base_cfg <= PTA_BASE_CFG_RST;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign o_scl                = r_ff.pin_lo;
  assign o_scl_oe             = r_ff.scl_oe;
  assign o_sda                = r_ff.pin_lo;
  assign o_sda_oe             = r_ff.sda_oe;
  assign o_target_addr        = r_ff.addr;
  assign o_addr_locked        = r_ff.locked;
  assign o_target_base_config = r_ff.base_cfg;

endmodule

//--- hw/pta_pkg.sv
// Purpose: shared constants and types of the management-bus target
// Assumes: 100 MHz core clock
// Notes:   command codes other than clear-faults and base config are the usual ones of the bus

package pta_pkg;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] PTA_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] PTA_CMD_BASE_CFG     = 8'he0;
  localparam logic [7:0] PTA_CMD_STAT_BYTE    = 8'h78;
  localparam logic [7:0] PTA_CMD_STAT_WORD    = 8'h79;
  localparam logic [7:0] PTA_CMD_STAT_VOUT    = 8'h7a;
  localparam logic [7:0] PTA_CMD_STAT_IOUT    = 8'h7b;
  localparam logic [7:0] PTA_CMD_STAT_INPUT   = 8'h7c;
  localparam logic [7:0] PTA_CMD_STAT_TEMP    = 8'h7d;
  localparam logic [7:0] PTA_CMD_STAT_CML     = 8'h7e;
  localparam logic [7:0] PTA_CMD_STAT_MFR     = 8'h80;
  localparam logic [7:0] PTA_CMD_READ_VIN     = 8'h88;
  localparam logic [7:0] PTA_CMD_READ_VOUT    = 8'h8b;
  localparam logic [7:0] PTA_CMD_READ_IOUT    = 8'h8c;
  localparam logic [7:0] PTA_CMD_READ_TEMP    = 8'h8d;
  localparam logic [7:0] PTA_CMD_READ_POUT    = 8'h96;

  // ****************************************
  // register layout and reset values
  // ****************************************
  localparam logic [7:0] PTA_BASE_CFG_RST  = 8'h60;
  localparam int         PTA_BASE_MSB      = 7;
  localparam int         PTA_BASE_LSB      = 5;
  localparam logic [3:0] PTA_STRAP_OPEN    = 4'hf;
  localparam logic [7:0] PTA_NO_DATA       = 8'hff;
  localparam int         PTA_CML_BADCMD    = 7;
  localparam int         PTA_OVW_BUSY      = 7;
  localparam int         PTA_OVW_OFF       = 6;
  localparam int         PTA_OVW_VOUT_OV   = 5;
  localparam int         PTA_OVW_IOUT_OC   = 4;
  localparam int         PTA_OVW_VIN_UV    = 3;
  localparam int         PTA_OVW_TEMP      = 2;
  localparam int         PTA_OVW_CML       = 1;
  localparam int         PTA_OVW_OTHER     = 0;
  localparam int         PTA_INP_UV_BIT    = 4;
  localparam int         PTA_HI_VOUT       = 7;
  localparam int         PTA_HI_IOUT       = 6;
  localparam int         PTA_HI_INPUT      = 5;
  localparam int         PTA_HI_MFR        = 4;
  localparam int         PTA_HI_PG_N       = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam real PTA_CLK_MHZ     = 100.0;
  localparam real PTA_REFRESH_MS  = 0.25;
  localparam int  PTA_REFRESH_CYC = int'($floor(PTA_REFRESH_MS * 1000.0 * PTA_CLK_MHZ));
  localparam int  PTA_REFR_W      = 16;
  localparam int  PTA_SYNC_W      = 7;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] pout;
    logic [15:0] temp;
  } pta_telem_t;

  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] vin;
    logic [7:0] temp;
    logic [7:0] cml;
    logic [7:0] mfr;
  } pta_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_RX,
    ST_RXACK,
    ST_TX,
    ST_TXACK
  } pta_state_t;

endpackage

//--- hw/pta_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are slow levels or bus lines far below the core clock
// Notes:   multi-bit strap code is static, so per-bit skew is harmless

`timescale 1ns/1ps

module pta_sync
  import pta_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic [PTA_SYNC_W-1:0] i_async,
  output logic      [PTA_SYNC_W-1:0] o_sync
);

  typedef struct packed {
    logic [PTA_SYNC_W-1:0] meta;
    logic [PTA_SYNC_W-1:0] sync;
  } pta_sync_regs_t;

  pta_sync_regs_t r_ff;
  pta_sync_regs_t nxt_r;

  always_comb
  begin
    nxt_r      = r_ff;
    nxt_r.meta = i_async;
    nxt_r.sync = r_ff.meta;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      // idle-high reset keeps the bus edge detectors quiet after release
      r_ff <= '1;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign o_sync = r_ff.sync;

endmodule

//--- tb/pta_target_properties.sv
// Purpose: port-level assertions for the management-bus target
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound into every pta_target instance
`timescale 1ns/1ps
module pta_target_chk
  import pta_pkg::*;
#(
  parameter int REFRESH_CYCLES = PTA_REFRESH_CYC
)
(
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic [3:0] i_strap_resistor,
  input wire logic       i_strap_open,
  input wire logic [7:0] i_nvm_base,
  input wire logic       i_busy,
  input wire logic       i_output_off,
  input wire logic       i_power_good,
  input wire pta_stat_t  i_stat_set,
  input wire pta_telem_t i_telem,
  input wire logic       o_scl,
  input wire logic       o_scl_oe,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  input wire logic [6:0] o_target_addr,
  input wire logic       o_addr_locked,
  input wire logic [7:0] o_target_base_config
);
  logic [7:0] sum_addr;
  // open pin wins over whatever the measurement says
  assign sum_addr = {i_nvm_base[7:5], 5'h00} + {4'h0, (i_strap_open ? 4'hf : i_strap_resistor)};
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ****************************************
  // assertions
  // ****************************************
  chk_lock_delay: assert property ($fell(i_rst) |-> !o_addr_locked [*4] ##1 o_addr_locked)
    else $error("address lock not on fourth edge after reset");
  chk_addr_sum: assert property ($rose(o_addr_locked) |-> o_target_addr == sum_addr[6:0])
    else $error("bus address is not base plus strap index");
  chk_addr_hold: assert property (o_addr_locked |=> $stable(o_target_addr))
    else $error("bus address moved without a power cycle");
  chk_cfg_default: assert property (!o_addr_locked |-> o_target_base_config == PTA_BASE_CFG_RST)
    else $error("base config not at default before lock");
  chk_quiet_unlocked: assert property (!o_addr_locked |-> !o_sda_oe && !o_scl_oe)
    else $error("bus driven before address lock");
  chk_stretch_cause: assert property (o_scl_oe |-> $past(i_busy))
    else $error("clock held low without busy");
  chk_sda_on_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  chk_pull_low: assert property (o_sda_oe || o_scl_oe |-> !o_sda && !o_scl)
    else $error("enabled line not pulled low");
endmodule

bind pta_target pta_target_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
  .i_strap_resistor(i_strap_resistor), .i_strap_open(i_strap_open), .i_nvm_base(i_nvm_base),
  .i_busy(i_busy), .i_output_off(i_output_off), .i_power_good(i_power_good),
  .i_stat_set(i_stat_set), .i_telem(i_telem), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_target_addr(o_target_addr),
  .o_addr_locked(o_addr_locked), .o_target_base_config(o_target_base_config));

//--- tb/pta_host_model.sv
// Purpose: behavioural bus host for the target's clock and data lines
// Assumes: open-drain lines resolved with pull-ups in the bench
// Notes:   t_low and t_high in core clocks; no error-check byte is ever sent
`timescale 1ns/1ps
module pta_host_model
(
  input  wire logic i_clock,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  int t_low  = 130;
  int t_high = 60;
  initial
  begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // release clock, then sit out any stretch by the target
  task automatic scl_high();
    int n;
    n = 0;
    o_scl_oe = 1'b0;
    wait_cyc(1);
    while (i_scl !== 1'b1 && n < 100000)
    begin
      wait_cyc(1);
      n++;
    end
    wait_cyc(t_high);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wait_cyc(2);
    o_sda_oe = !b;
    wait_cyc(t_low);
    scl_high();
    r = i_sda;
    o_scl_oe = 1'b1;
  endtask
  task automatic bus_start();
    wait_cyc(2);
    o_sda_oe = 1'b0;
    wait_cyc(t_low);
    scl_high();
    o_sda_oe = 1'b1;
    wait_cyc(t_high);
    o_scl_oe = 1'b1;
  endtask
  task automatic bus_stop();
    wait_cyc(2);
    o_sda_oe = 1'b1;
    wait_cyc(t_low);
    scl_high();
    o_sda_oe = 1'b0;
    wait_cyc(130);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(output logic [7:0] b, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

//--- tb/tb_pta_target.sv
// Purpose: self-checking bench for the management-bus target
// Assumes: host model drives the bus, bench drives straps and status
// Notes:   refresh count shortened to keep the run small
`timescale 1ns/1ps
module tb_pta_target
  import pta_pkg::*;
;
  localparam int RC = 20;
  logic       clk, rst, strap_open, busy, out_off, pg, ack;
  logic       h_scl_oe, h_sda_oe, d_scl, d_scl_oe, d_sda, d_sda_oe, locked;
  logic [3:0] strap;
  logic [6:0] taddr;
  logic [7:0] nvm, bcfg;
  logic [47:0] sv;
  pta_stat_t  stat_set;
  pta_telem_t telem;
  wire logic  scl_w = ~(h_scl_oe | d_scl_oe);
  wire logic  sda_w = ~(h_sda_oe | d_sda_oe);
  int         seed = 36;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         exp_grp[6];
  int         exp_busy, exp_addr;
  int         exp_q[$];
  logic [7:0] grp_cmd[6] = '{PTA_CMD_STAT_VOUT, PTA_CMD_STAT_IOUT, PTA_CMD_STAT_INPUT,
                             PTA_CMD_STAT_TEMP, PTA_CMD_STAT_CML, PTA_CMD_STAT_MFR};
  pta_target #(.REFRESH_CYCLES(RC)) u_dut (
    .i_clock(clk), .i_rst(rst), .i_scl(scl_w), .i_sda(sda_w), .i_strap_resistor(strap),
    .i_strap_open(strap_open), .i_nvm_base(nvm), .i_busy(busy), .i_output_off(out_off),
    .i_power_good(pg), .i_stat_set(stat_set), .i_telem(telem), .o_scl(d_scl), .o_scl_oe(d_scl_oe),
    .o_sda(d_sda), .o_sda_oe(d_sda_oe), .o_target_addr(taddr), .o_addr_locked(locked),
    .o_target_base_config(bcfg));
  pta_host_model u_host (.i_clock(clk), .i_scl(scl_w), .i_sda(sda_w), .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe));
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %0s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [7:0] base, input logic open);
    rst = 1'b1;
    nvm = base;
    strap = 4'($random(seed));
    strap_open = open;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    exp_addr = (int'(base[7:5]) * 32 + (open ? 15 : int'(strap))) % 128;
    exp_busy = 0;
    foreach (exp_grp[g]) exp_grp[g] = 0;
    check({1'b0, taddr}, 8'(exp_addr), "address");
    check(bcfg, base, "base config after reset");
  endtask
  task automatic wr_cmd(input logic [7:0] cmd, input int n, input logic [7:0] d);
    u_host.bus_start();
    u_host.wr_byte({7'(exp_addr), 1'b0}, ack);
    check({7'h0, ack}, 8'h01, "address ack");
    u_host.wr_byte(cmd, ack);
    if (n > 0)
      u_host.wr_byte(d, ack);
    u_host.bus_stop();
  endtask
  task automatic rd_cmd(input logic [7:0] cmd, input int n, input string what);
    logic [7:0] b;
    u_host.bus_start();
    u_host.wr_byte({7'(exp_addr), 1'b0}, ack);
    u_host.wr_byte(cmd, ack);
    u_host.bus_start();
    u_host.wr_byte({7'(exp_addr), 1'b1}, ack);
    for (int i = 0; i < n; i++)
    begin
      u_host.rd_byte(b, i < n - 1);
      check(b, 8'(exp_q.pop_front()), what);
    end
    u_host.bus_stop();
  endtask
  task automatic read_word();
    logic [7:0] lo, hi;
    lo = {exp_busy[0], out_off, exp_grp[0][7], exp_grp[1][7], exp_grp[2][4], |exp_grp[3],
          |exp_grp[4], (|exp_grp[5]) | (|exp_grp[2])};
    hi = {|exp_grp[0], |exp_grp[1], |exp_grp[2], |exp_grp[5], !pg, 3'h0};
    exp_q = {int'(lo), int'(hi)};
    rd_cmd(PTA_CMD_STAT_WORD, 2, "status word");
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (150000) @(posedge clk); // about a third again the planned run
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    busy = 1'b0;
    out_off = 1'b0;
    pg = 1'b1;
    stat_set = '0;
    telem = '0;
    for (int k = 0; k < 4; k++)
      do_reset(8'($random(seed)), k[0]);
    do_reset(PTA_BASE_CFG_RST, 1'b0);
    $display("test addressing done");
    u_host.bus_start();
    u_host.wr_byte({7'(exp_addr + 1), 1'b0}, ack);
    u_host.bus_stop();
    check({7'h0, ack}, 8'h00, "foreign address");
    wr_cmd(PTA_CMD_BASE_CFG, 1, 8'h40);
    check(bcfg, 8'h40, "written base");
    check({1'b0, taddr}, 8'(exp_addr), "address kept");
    do_reset(8'h40, 1'b0);
    $display("test base change done");
    out_off = 1'b1;
    sv = 48'({$random(seed), $random(seed)});
    stat_set = sv;
    foreach (exp_grp[g]) exp_grp[g] |= int'(sv[47 - 8 * g -: 8]);
    @(posedge clk);
    #1 stat_set = '0;
    out_off = 1'b0; // output re-enabled, latched status must survive
    wr_cmd(8'h55, 0, 8'h00);
    exp_grp[4] |= 1 << PTA_CML_BADCMD;
    fork
      for (int g = 0; g < 6; g++)
      begin
        exp_q.push_back(exp_grp[g]);
        rd_cmd(grp_cmd[g], 1, "status group");
      end
      begin
        repeat (3000) @(posedge clk);
        #1 busy = 1'b1;
        repeat (400) @(posedge clk);
        #1 busy = 1'b0;
      end
    join
    exp_busy = 1;
    pg = 1'($random(seed));
    read_word();
    $display("test status latch done");
    u_host.t_low = 500;
    u_host.t_high = 500;
    wr_cmd(PTA_CMD_CLEAR_FAULTS, 0, 8'h00);
    u_host.t_low = 130;
    u_host.t_high = 60;
    exp_busy = 0;
    foreach (exp_grp[g]) exp_grp[g] = 0;
    pg = ~pg;
    read_word();
    $display("test clear done");
    telem = 80'({$random(seed), $random(seed), $random(seed)});
    repeat (RC + 2) @(posedge clk);
    #1 exp_q = {int'(telem.vin[7:0]), int'(telem.vin[15:8]), 255};
    rd_cmd(PTA_CMD_READ_VIN, 3, "input voltage");
    $display("test telemetry done");
    report_and_stop();
  end
endmodule
